// >>> logic/aof_params.svh
// Constants of the output formatter: offsets, fields, reset values, patterns
`ifndef AOF_PARAMS_SVH
`define AOF_PARAMS_SVH
`define AOF_ADDR_W      13
`define AOF_OFS_TEST    13'h00D
`define AOF_OFS_MODE    13'h014
`define AOF_OFS_SWING   13'h015
`define AOF_OFS_LINK    13'h021
`define AOF_RST_TEST    8'h00
`define AOF_RST_MODE    8'h00
`define AOF_RST_SWING   8'h00
`define AOF_RST_LINK    8'h08
`define AOF_MASK_TEST   8'h7F
`define AOF_MASK_MODE   8'h0F
`define AOF_MASK_LINK   8'h08
`define AOF_FMT_LO      0
`define AOF_FMT_HI      1
`define AOF_INV_BIT     2
`define AOF_REV_BIT     3
`define AOF_PLL_BIT     3
`define AOF_TM_LO       0
`define AOF_TM_HI       3
`define AOF_LEN_LO      4
`define AOF_LEN_HI      6
`define AOF_LEN_PIVOT   3'h5
`define AOF_LEN_MAXC    3'h4
`define AOF_MID         12'h800
`define AOF_FULL        12'hFFF
`define AOF_ZERO        12'h000
`define AOF_CHK_A       12'hAAA
`define AOF_CHK_B       12'h555
`define AOF_FULL8       12'hFF0
`define AOF_FULL9       12'hFF8
`define AOF_FULL10      12'hFFC
`define AOF_FULL11      12'hFFE
`define AOF_SEED_S      9'h0DF
`define AOF_SEED_L      23'h29B80A
`define AOF_PNS_W0      12'hDF9
`define AOF_PNL_W0      12'h591
`define AOF_PN_BITS     12
`define AOF_TAIL        4'h0
`define AOF_RW_BIT      15
`define AOF_INSTR_LAST  4'hF
`define AOF_BYTE_LAST   3'h7
`define AOF_FIFO_DEPTH  4
`endif

// >>> logic/aof_pkg.sv
// Types of the output formatter
package aof_pkg;
	`include "aof_params.svh"
	typedef enum logic [1:0] {AOF_FMT_OFFSET = 2'b00, AOF_FMT_TWOS = 2'b01, AOF_FMT_GRAY = 2'b10} aof_fmt_t;
	typedef enum logic [3:0] {
		AOF_TM_OFF = 4'b0000, AOF_TM_MID = 4'b0001, AOF_TM_PFS = 4'b0010, AOF_TM_NFS = 4'b0011,
		AOF_TM_CHK = 4'b0100, AOF_TM_PNL = 4'b0101, AOF_TM_PNS = 4'b0110, AOF_TM_TOG = 4'b0111
	} aof_tm_t;
	typedef enum logic {AOF_PH_INSTR = 1'b0, AOF_PH_DATA = 1'b1} aof_ph_t;
	typedef struct packed {logic [3:0][11:0] w;} aof_quad_t;
	typedef struct packed {logic [3:0][7:0] o; logic second;} aof_oct_t;
	typedef struct packed {
		logic [7:0]  reg_test;
		logic [7:0]  reg_mode;
		logic [7:0]  reg_swing;
		logic [7:0]  reg_link;
		logic        alt;
		logic [8:0]  pns;
		logic [22:0] pnl;
		logic        sclk_q;
		aof_ph_t     ph;
		logic [3:0]  cnt;
		logic [15:0] sh;
		logic        rw;
		logic [12:0] addr;
		logic [7:0]  rdsh;
		logic        sdio_o;
		logic        sdio_oe;
		aof_oct_t    oct;
		logic        oct_valid;
		logic        phase;
		aof_quad_t   word;
	} aof_st_t;
	localparam aof_st_t AOF_ST_RST = '{reg_test: `AOF_RST_TEST, reg_mode: `AOF_RST_MODE,
		reg_swing: `AOF_RST_SWING, reg_link: `AOF_RST_LINK, pns: `AOF_SEED_S, pnl: `AOF_SEED_L,
		ph: AOF_PH_INSTR, default: '0};
endpackage

// >>> logic/aof_top.sv
// Output format, test pattern, octet split and register port of a quad converter
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "aof_params.svh"

module aof_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rd;
		logic [AW-1:0]               wr;
		logic [AW:0]                 cnt;
		logic                        rdy;
		logic                        vld;
	} aof_fifo_st_t;
	aof_fifo_st_t s, n;
	logic push, pop;

	assign push      = in_valid && s.rdy;
	assign pop       = out_ready && s.vld;
	assign in_ready  = s.rdy;
	assign out_valid = s.vld;
	assign out_data  = s.mem[s.rd];

	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wr] = in_data;
			n.wr = s.wr + 1'b1;
		end
		if (pop)
			n.rd = s.rd + 1'b1;
		n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		n.rdy = n.cnt != (AW+1)'(DEPTH);
		n.vld = n.cnt != '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{rdy: 1'b1, default: '0};
		end else begin
			s <= n;
		end
	end
endmodule // aof_fifo

module aof_top (
	input  wire logic             CLK_SYS,
	input  wire logic             RESETN,
	input  wire aof_pkg::aof_quad_t SAMPLE,
	input  wire logic             SAMPLE_VALID,
	output logic                  SAMPLE_READY,
	output aof_pkg::aof_oct_t     OCT,
	output logic                  OCT_VALID,
	input  wire logic             OCT_READY,
	input  wire logic             CSB,
	input  wire logic             SCLK,
	input  wire logic             SDIO_I,
	output logic                  SDIO_O,
	output logic                  SDIO_OE,
	output logic      [7:0]       DRIVE_SWING,
	output logic                  PLL_BW_HIGH
);
	import aof_pkg::*;

	aof_st_t   s, n;
	aof_quad_t fw, fifo_q;
	aof_fmt_t  fmt_sel;
	aof_tm_t   tm;
	logic      inv, rev, push, pop, fifo_rdy, fifo_vld, pat_sel, pat_fmt, rise, fall;
	logic [2:0]  len;
	logic [11:0] pat, pns_w, pnl_w;
	logic [8:0]  pns_nx;
	logic [22:0] pnl_nx;

	// ------------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------------
	function automatic logic [7:0] reg_read(input aof_st_t st, input logic [12:0] a);
		case (a)
			`AOF_OFS_TEST:  reg_read = st.reg_test;
			`AOF_OFS_MODE:  reg_read = st.reg_mode;
			`AOF_OFS_SWING: reg_read = st.reg_swing;
			`AOF_OFS_LINK:  reg_read = st.reg_link;
			default:        reg_read = 8'h00;
		endcase
	endfunction

	function automatic logic [11:0] finish(input logic [11:0] w, input logic f_en, input aof_fmt_t f,
		input logic iv, input logic rv);
		logic [11:0] t;
		t = w;
		if (f_en) begin
			case (f)
				AOF_FMT_TWOS: t = {~w[11], w[10:0]};
				AOF_FMT_GRAY: t = w ^ (w >> 1);
				default:      t = w;
			endcase
		end
		if (iv)
			t = ~t;
		finish = t;
		if (rv) begin
			for (int i = 0; i < 12; i++)
				finish[i] = t[11-i];
		end
	endfunction

	function automatic logic [20:0] pn_short(input logic [8:0] st);
		logic [8:0]  r;
		logic [11:0] w;
		r = st;
		w = '0;
		for (int i = 0; i < `AOF_PN_BITS; i++) begin
			w = {w[10:0], r[7]};
			r = {r[7:0], r[8] ^ r[4]};
		end
		pn_short = {r, w};
	endfunction

	function automatic logic [34:0] pn_long(input logic [22:0] st);
		logic [22:0] r;
		logic [11:0] w;
		r = st;
		w = '0;
		for (int i = 0; i < `AOF_PN_BITS; i++) begin
			w = {w[10:0], ~r[21]};
			r = {r[21:0], r[22] ^ r[17]};
		end
		pn_long = {r, w};
	endfunction

	function automatic logic [11:0] len_mask(input logic [2:0] c);
		if (c == 3'h0 || c > `AOF_LEN_MAXC)
			len_mask = `AOF_FULL;
		else
			len_mask = `AOF_FULL << (`AOF_LEN_PIVOT - c);
	endfunction

	// ------------------------------------------------------------------------
	// Pattern source and format
	// ------------------------------------------------------------------------
	assign fmt_sel = aof_fmt_t'(s.reg_mode[`AOF_FMT_HI:`AOF_FMT_LO]);
	assign inv     = s.reg_mode[`AOF_INV_BIT];
	assign rev     = s.reg_mode[`AOF_REV_BIT];
	assign tm      = aof_tm_t'(s.reg_test[`AOF_TM_HI:`AOF_TM_LO]);
	assign len     = s.reg_test[`AOF_LEN_HI:`AOF_LEN_LO];
	assign push    = SAMPLE_VALID && fifo_rdy;
	assign {pns_nx, pns_w} = pn_short(s.pns);
	assign {pnl_nx, pnl_w} = pn_long(s.pnl);
	assign pat_sel = tm != AOF_TM_OFF;
	assign pat_fmt = tm != AOF_TM_CHK && tm != AOF_TM_TOG;

	always_comb begin
		case (tm)
			AOF_TM_MID: pat = `AOF_MID & len_mask(len);
			AOF_TM_PFS: pat = `AOF_FULL & len_mask(len);
			AOF_TM_NFS: pat = `AOF_ZERO;
			AOF_TM_CHK: pat = (s.alt ? `AOF_CHK_B : `AOF_CHK_A) & len_mask(len);
			AOF_TM_TOG: pat = (s.alt ? `AOF_ZERO : `AOF_FULL) & len_mask(len);
			AOF_TM_PNL: pat = pnl_w;
			AOF_TM_PNS: pat = pns_w;
			default:    pat = `AOF_ZERO;
		endcase
	end

	for (genvar ch = 0; ch < 4; ch++) begin : g_ch
		assign fw.w[ch] = finish(pat_sel ? pat : SAMPLE.w[ch], pat_fmt, fmt_sel, inv, rev);
	end

	aof_fifo #(
		.WIDTH ($bits(aof_quad_t)),
		.DEPTH (`AOF_FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst_n     (RESETN),
		.in_valid  (SAMPLE_VALID),
		.in_ready  (fifo_rdy),
		.in_data   (fw),
		.out_valid (fifo_vld),
		.out_ready (pop),
		.out_data  (fifo_q)
	);

	assign pop  = (!s.oct_valid || OCT_READY) && !s.phase && fifo_vld;
	assign rise = SCLK && !s.sclk_q;
	assign fall = !SCLK && s.sclk_q;

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		n = s;
		n.pns = (tm != AOF_TM_PNS) ? `AOF_SEED_S : (push ? pns_nx : s.pns);
		n.pnl = (tm != AOF_TM_PNL) ? `AOF_SEED_L : (push ? pnl_nx : s.pnl);
		if (tm != AOF_TM_CHK && tm != AOF_TM_TOG)
			n.alt = 1'b0;
		else if (push)
			n.alt = !s.alt;
		if (!s.oct_valid || OCT_READY) begin
			if (s.phase) begin
				for (int c = 0; c < 4; c++)
					n.oct.o[c] = {s.word.w[c][3:0], `AOF_TAIL};
				n.oct.second = 1'b1;
				n.oct_valid  = 1'b1;
				n.phase      = 1'b0;
			end else if (fifo_vld) begin
				n.word = fifo_q;
				for (int c = 0; c < 4; c++)
					n.oct.o[c] = fifo_q.w[c][11:4];
				n.oct.second = 1'b0;
				n.oct_valid  = 1'b1;
				n.phase      = 1'b1;
			end else begin
				n.oct_valid = 1'b0;
			end
		end
		n.sclk_q = SCLK;
		if (CSB) begin
			n.ph      = AOF_PH_INSTR;
			n.cnt     = 4'h0;
			n.sdio_oe = 1'b0;
		end else begin
			if (rise) begin
				n.sh  = {s.sh[14:0], SDIO_I};
				n.cnt = s.cnt + 4'h1;
				if (s.ph == AOF_PH_INSTR && s.cnt == `AOF_INSTR_LAST) begin
					n.ph   = AOF_PH_DATA;
					n.cnt  = 4'h0;
					n.rw   = n.sh[`AOF_RW_BIT];
					n.addr = n.sh[12:0];
					n.rdsh = reg_read(s, n.sh[12:0]);
				end else if (s.ph == AOF_PH_DATA && s.cnt[2:0] == `AOF_BYTE_LAST) begin
					n.cnt  = 4'h0;
					n.addr = s.addr + 13'h1;
					n.rdsh = reg_read(s, n.addr);
					if (!s.rw) begin
						case (s.addr)
							`AOF_OFS_TEST:  n.reg_test  = n.sh[7:0] & `AOF_MASK_TEST;
							`AOF_OFS_MODE:  n.reg_mode  = n.sh[7:0] & `AOF_MASK_MODE;
							`AOF_OFS_SWING: n.reg_swing = n.sh[7:0];
							`AOF_OFS_LINK:  n.reg_link  = n.sh[7:0] & `AOF_MASK_LINK;
							default:        n.reg_link  = s.reg_link;
						endcase
					end
				end
			end
			if (fall && s.ph == AOF_PH_DATA && s.rw) begin
				n.sdio_o  = s.rdsh[7];
				n.sdio_oe = 1'b1;
				n.rdsh    = {s.rdsh[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			s <= AOF_ST_RST;
		end else begin
			s <= n;
		end
	end

	assign SAMPLE_READY = fifo_rdy;
	assign OCT          = s.oct;
	assign OCT_VALID    = s.oct_valid;
	assign SDIO_O       = s.sdio_o;
	assign SDIO_OE      = s.sdio_oe;
	assign DRIVE_SWING  = s.reg_swing;
	assign PLL_BW_HIGH  = s.reg_link[`AOF_PLL_BIT];

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	logic plain;
	assign plain = !inv && !rev && len == 3'h0;

	offset_pass_a: assert property (push && tm == AOF_TM_OFF && fmt_sel == AOF_FMT_OFFSET && plain |-> fw == SAMPLE)
		else $error("offset binary pass-through wrong");
	gray_fmt_a: assert property (push && tm == AOF_TM_OFF && fmt_sel == AOF_FMT_GRAY && plain
		|-> fw.w[0] == (SAMPLE.w[0] ^ (SAMPLE.w[0] >> 1)))
		else $error("gray code wrong");
	invert_mid_a: assert property (push && tm == AOF_TM_MID && fmt_sel == AOF_FMT_OFFSET && inv && !rev && len == 3'h0
		|-> fw.w[1] == ~`AOF_MID)
		else $error("inverted midscale wrong");
	lsb_first_a: assert property (push && tm == AOF_TM_OFF && fmt_sel == AOF_FMT_OFFSET && rev && !inv
		|-> fw.w[0][0] == SAMPLE.w[0][11] && fw.w[0][11] == SAMPLE.w[0][0])
		else $error("bit order not reversed");
	full_len_a: assert property (push && tm == AOF_TM_PFS && fmt_sel == AOF_FMT_OFFSET && !inv && !rev
		|-> fw.w[2] == (len == 3'h1 ? `AOF_FULL8 : len == 3'h2 ? `AOF_FULL9 : len == 3'h3 ? `AOF_FULL10
		: len == 3'h4 ? `AOF_FULL11 : `AOF_FULL))
		else $error("full scale pattern wrong");
	chk_bypass_a: assert property (push && tm == AOF_TM_CHK && plain ##1 push && tm == AOF_TM_CHK && plain
		|-> (fw.w[3] == `AOF_CHK_B && $past(fw.w[3]) == `AOF_CHK_A)
		|| (fw.w[3] == `AOF_CHK_A && $past(fw.w[3]) == `AOF_CHK_B))
		else $error("checkerboard alternation wrong");
	pn_first_a: assert property (push && tm == AOF_TM_PNS && s.pns == `AOF_SEED_S && fmt_sel == AOF_FMT_OFFSET && plain
		|-> fw.w[3] == `AOF_PNS_W0)
		else $error("short PN first word wrong");
	pnl_first_a: assert property (push && tm == AOF_TM_PNL && s.pnl == `AOF_SEED_L && fmt_sel == AOF_FMT_OFFSET && plain
		|-> fw.w[0] == `AOF_PNL_W0)
		else $error("long PN first word wrong");
	pn_reseed_a: assert property (tm != AOF_TM_PNS && tm != AOF_TM_PNL
		|=> s.pns == `AOF_SEED_S && s.pnl == `AOF_SEED_L)
		else $error("PN seed not restored");
	octet_pair_a: assert property (OCT_VALID && !OCT.second && OCT_READY
		|=> OCT_VALID && OCT.second && OCT.o[0][3:0] == `AOF_TAIL)
		else $error("second octet missing");

	pn_short_c: cover property (push && tm == AOF_TM_PNS ##1 push && tm == AOF_TM_PNS);
	octet_pair_c: cover property (OCT_VALID && OCT.second && OCT_READY);
	spi_read_c: cover property (s.ph == AOF_PH_DATA && s.rw && fall);
	fifo_full_c: cover property (SAMPLE_VALID && !SAMPLE_READY);
endmodule // aof_top

// >>> tb/aof_rx_model.sv
// Receiver model: paces the octet stream and rebuilds words
`timescale 1ns/1ps

module aof_rx_model
	import aof_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire logic     slow,
	input  wire aof_oct_t oct,
	input  wire logic     oct_valid,
	output logic          ready,
	output aof_quad_t     got,
	output logic          got_stb,
	output logic          pair_err
);
	logic [3:0][7:0] hi;
	logic            have_hi;
	logic [7:0]      lf = 8'h5A;

	// ------
	// Stalls
	// ------
	always @(negedge clk) begin
		lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
	end
	assign ready = !slow || lf[0];

	// ---------------
	// Octet pairing
	// ---------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			have_hi <= 1'b0;
			got_stb <= 1'b0;
			pair_err <= 1'b0;
			got <= '0;
		end else begin
			got_stb <= 1'b0;
			if (oct_valid && ready) begin
				if (!oct.second) begin
					if (have_hi) pair_err <= 1'b1;
					hi <= oct.o;
					have_hi <= 1'b1;
				end else begin
					for (int c = 0; c < 4; c++) begin
						got.w[c] <= {hi[c], oct.o[c][7:4]};
						if (oct.o[c][3:0] != 4'h0) pair_err <= 1'b1;
					end
					if (!have_hi) pair_err <= 1'b1;
					got_stb <= 1'b1;
					have_hi <= 1'b0;
				end
			end
		end
	end
endmodule // aof_rx_model

// >>> tb/aof_top_bench.sv
// Self-checking bench of the output formatter
`timescale 1ns/1ps

module aof_top_bench;
	import aof_pkg::*;
	localparam logic [11:0] PNL [3] = '{12'h591, 12'hFD7, 12'h0A3};
	localparam logic [11:0] PNS [3] = '{12'hDF9, 12'h353, 12'h301};
	localparam logic [11:0] CRN [4] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
	localparam logic [12:0] RA  [5] = '{13'h00D, 13'h014, 13'h015, 13'h021, 13'h033};
	localparam logic [7:0]  RV  [5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
	localparam logic [7:0]  RM  [5] = '{8'h7F, 8'h0F, 8'hFF, 8'h08, 8'h00};
	localparam logic [3:0]  TMS [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h6};
	localparam logic [7:0]  MDS [8] = '{8'h04, 8'h00, 8'h01, 8'h02, 8'h00, 8'h0A, 8'h01, 8'h00};
	localparam logic [2:0]  LNS [8] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h0};
	logic        clk;
	logic        rst_n;
	aof_quad_t   smp;
	logic        smp_vld;
	logic        smp_rdy;
	aof_oct_t    oct;
	logic        oct_vld;
	logic        oct_rdy;
	logic        csb;
	logic        sclk;
	logic        host_d;
	wire logic   sdio_i;
	logic        sdio_o;
	logic        sdio_oe;
	logic [7:0]  swing;
	logic        pll_hi;
	logic        slow;
	aof_quad_t   got;
	logic        got_stb;
	logic        pair_err;
	logic [7:0]  md;
	logic [2:0]  ln;
	logic        full_seen;
	int          fails = 0;
	int          compares = 0;
	aof_quad_t   exp_q [$];

	assign sdio_i = sdio_oe ? sdio_o : host_d;

	aof_top dut (
		.CLK_SYS      (clk),
		.RESETN       (rst_n),
		.SAMPLE       (smp),
		.SAMPLE_VALID (smp_vld),
		.SAMPLE_READY (smp_rdy),
		.OCT          (oct),
		.OCT_VALID    (oct_vld),
		.OCT_READY    (oct_rdy),
		.CSB          (csb),
		.SCLK         (sclk),
		.SDIO_I       (sdio_i),
		.SDIO_O       (sdio_o),
		.SDIO_OE      (sdio_oe),
		.DRIVE_SWING  (swing),
		.PLL_BW_HIGH  (pll_hi)
	);

	aof_rx_model rx (
		.clk       (clk),
		.rst_n     (rst_n),
		.slow      (slow),
		.oct       (oct),
		.oct_valid (oct_vld),
		.ready     (oct_rdy),
		.got       (got),
		.got_stb   (got_stb),
		.pair_err  (pair_err)
	);

	// -------
	// Helpers
	// -------
	task automatic check(input logic [47:0] seen, input logic [47:0] want);
		compares++;
		if (seen !== want) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic results;
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [11:0] fmt_w(input logic [3:0] tm, input logic [11:0] s, input int k);
		logic [11:0] x;
		case (tm)
			4'h0: x = s;
			4'h1: x = 12'h800;
			4'h2: x = 12'hFFF;
			4'h3: x = 12'h000;
			4'h4: x = k[0] ? 12'h555 : 12'hAAA;
			4'h5: x = PNL[k];
			4'h6: x = PNS[k];
			default: x = k[0] ? 12'h000 : 12'hFFF;
		endcase
		if ((tm == 4'h1 || tm == 4'h2 || tm == 4'h4 || tm == 4'h7) && ln inside {[3'h1:3'h4]})
			x = x & (12'hFFF << (3'h5 - ln));
		if (tm != 4'h4 && tm != 4'h7) begin
			if (md[1:0] == 2'b01) x = x ^ 12'h800;
			if (md[1:0] == 2'b10) x = x ^ (x >> 1);
		end
		if (md[2]) x = ~x;
		if (md[3]) x = {<<{x}};
		return x;
	endfunction

	task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
		logic [23:0] f;
		f = {rd, 2'b00, a, wd};
		q = 8'h00;
		csb = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			host_d = (rd && i < 8) ? 1'b0 : f[i];
			repeat (3) @(negedge clk);
			if (i < 8) q[i] = sdio_i;
			sclk = 1'b1;
			repeat (3) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (3) @(negedge clk);
		csb = 1'b1;
		repeat (3) @(negedge clk);
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] v;
		spi(1'b0, a, d, v);
	endtask

	task automatic send(input logic [3:0] tm, input int k);
		aof_quad_t s;
		aof_quad_t e;
		logic      r;
		for (int c = 0; c < 4; c++) begin
			s.w[c] = (k == 0) ? CRN[c] : 12'($urandom);
			e.w[c] = fmt_w(tm, s.w[c], k);
		end
		exp_q.push_back(e);
		smp = s;
		smp_vld = 1'b1;
		do begin
			r = smp_rdy;
			if (!r) full_seen = 1'b1;
			@(negedge clk);
		end while (!r);
	endtask

	task automatic idle;
		int n;
		smp_vld = 1'b0;
		n = 0;
		while (exp_q.size() > 0 && n < 400) begin
			@(negedge clk);
			n++;
		end
		check(48'(exp_q.size()), 48'h0);
	endtask

	always @(negedge clk) begin
		if (got_stb === 1'b1) check(got, exp_q.size() ? exp_q.pop_front() : 'x);
	end

	// -----------------
	// Clock and tests
	// -----------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#(20000 * 40);
		fails++;
		results();
	end

	initial begin
		logic [7:0] v;
		void'($urandom(32'h3961702d));
		{rst_n, csb, sclk, host_d, smp_vld, slow, full_seen} = 7'b0100000;
		smp = '0;
		md = 8'h00;
		ln = 3'h0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check(48'(swing), 48'h0);
		check(48'(pll_hi), 48'h1);
		for (int i = 0; i < 5; i++) begin
			spi(1'b1, RA[i], 8'h00, v);
			check(48'(v), 48'(RV[i]));
			wr(RA[i], 8'hFF);
			spi(1'b1, RA[i], 8'h00, v);
			check(48'(v), 48'(RM[i]));
		end
		check(48'(swing), 48'hFF);
		check(48'(pll_hi), 48'h1);
		wr(13'h021, 8'h00);
		check(48'(pll_hi), 48'h0);
		wr(13'h00D, 8'h00);
		for (int m = 0; m < 16; m++) begin
			md = 8'(m);
			wr(13'h014, md);
			for (int k = 0; k < 3; k++) send(4'h0, k);
			idle();
		end
		for (int t = 0; t < 16; t++) begin
			md = (t < 8) ? MDS[t[2:0]] : 8'($urandom_range(15, 0));
			ln = (t < 8) ? LNS[t[2:0]] : 3'($urandom_range(7, 0));
			wr(13'h014, md);
			wr(13'h00D, {1'b0, ln, TMS[t[2:0]]});
			for (int k = 0; k < 3; k++) send(TMS[t[2:0]], k);
			idle();
			wr(13'h00D, 8'h00);
		end
		slow = 1'b1;
		md = 8'($urandom_range(15, 0));
		wr(13'h014, md);
		for (int k = 0; k < 12; k++) send(4'h0, k);
		idle();
		slow = 1'b0;
		check(48'(full_seen), 48'h1);
		check(48'(pair_err), 48'h0);
		results();
	end
endmodule // aof_top_bench
